// File: tb/gkf_ctrl_bench.sv
// Self-checking bench for the group-key command framer controller
`include "gkf_consts.svh"
`default_nettype none
`define GKF_CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module gkf_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic         clk, rst, ce, psel, penable, pwrite, rx_valid;  // Bench-driven controls
	logic [7:0]   paddr, rx_byte;                                 // Address, received byte
	logic [31:0]  pwdata, prdata, rd;                             // Bus data
	logic         pready, pslverr, tx_valid, tx_ready, tx_last;   // Handshakes
	logic         tx_secure, busy, got;                           // Frame flags
	logic [7:0]   tx_byte, tx_enc_offset, tx_temporal_key_identifier;                // Stream fields
	logic [1:0]   tx_ack_policy;                                  // Ack policy
	logic [47:0]  tx_sfn, sfn_prev, cnt, rx_cnt;                  // Counters
	logic [8:0]   got_data, exp_b;                                // Captured and expected
	logic [3:0]   dly;                                            // Partner delay
	logic [23:0]  keyid, rx_id;                                   // Key identifiers
	logic [15:0]  gaddr, org;                                     // Address, specifier
	logic [127:0] key;                                            // Key material
	logic [8:0]   exp_q[$];                                       // Expected bytes
	bit           have_sfn;                                       // First frame seen
	int           miscompares, n_tests;                           // Tallies
	gkf_ctrl gkf_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_last(tx_last), .tx_secure(tx_secure), .tx_enc_offset(tx_enc_offset),
		.tx_ack_policy(tx_ack_policy), .tx_sfn(tx_sfn), .tx_temporal_key_identifier(tx_temporal_key_identifier),
		.rx_byte(rx_byte), .rx_valid(rx_valid), .busy(busy));
	gkf_dev_model gkf_dev_model_i (.clk(clk), .rst(rst), .tx_byte(tx_byte),
		.tx_valid(tx_valid), .tx_last(tx_last), .dly(dly), .tx_ready(tx_ready),
		.got(got), .got_data(got_data));
	// Clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Verdict and end of run
	task conclude;
		$display("Counts: %0d checks, %0d mismatches", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task tmo(input string nm);
		miscompares++;
		$display("Error %s timed out", nm);
		conclude();
	endtask
	// One APB transfer; read data lands in rd
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 50) tmo("apb");
		rd = prdata;
		`GKF_CHK("pslverr", 1'b0, pslverr)
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task push(input logic [7:0] b, input bit l = 1'b0);
		exp_q.push_back({l, b});
	endtask
	// Received byte on the async strobe, line scrambled when idle
	task rxb(input logic [7:0] b);
		rx_byte <= b;
		@(posedge clk);
		rx_valid <= 1'b1;
		repeat (3) @(posedge clk);
		rx_valid <= 1'b0;
		rx_byte <= ~b;
		repeat (3) @(posedge clk);
	endtask
	// Poll for done, then clear the flags
	task done_wait(input string nm);
		int i;
		for (i = 0; i < 3000; i++) begin
			apb(1'b0, `GKF_REG_STATUS, 32'h0);
			if (rd[3] === 1'b1) break;
		end
		if (i == 3000) tmo(nm);
		`GKF_CHK("busy", 1'b0, busy)
		`GKF_CHK("bytes_left", 0, exp_q.size())
		apb(1'b1, `GKF_REG_STATUS, 32'h0000000F);
		$display("Test %s done", nm);
	endtask
	// Group-key frame with expected payload
	task gk(input logic [7:0] msg, input logic [7:0] st, input bit dbl);
		logic [23:0]  idv;
		logic [47:0]  cv;
		logic [127:0] kv;
		int           i;
		idv = (msg == 8'h02) ? rx_id : keyid;
		cv = (msg == 8'h00) ? 48'h0 : ((msg == 8'h02) ? rx_cnt : cnt);
		kv = (msg == 8'h00) ? 128'h0 : key;
		push(msg);
		push(st);
		for (i = 0; i < 3; i++) push(idv[8*i+:8]);
		for (i = 0; i < 3; i++) push(8'h00);
		for (i = 0; i < 2; i++) push(gaddr[8*i+:8]);
		for (i = 0; i < 6; i++) push(cv[8*i+:8]);
		for (i = 0; i < 16; i++) push(kv[8*i+:8], i == 15);
		apb(1'b1, `GKF_REG_CTRL, {8'h5A, st, msg, 8'h01});
		for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
		if (i == 20) tmo("start");
		// Frame number output settles one edge after busy
		@(posedge clk);
		`GKF_CHK("temporal_key_identifier", 8'h5A, tx_temporal_key_identifier)
		`GKF_CHK("secure", 1'b1, tx_secure)
		if (have_sfn) `GKF_CHK("sfn", sfn_prev + 48'h1, tx_sfn)
		sfn_prev = tx_sfn;
		have_sfn = 1'b1;
		if (dbl) apb(1'b1, `GKF_REG_CTRL, {8'h5A, st, msg, 8'h01});
		done_wait("gk_frame");
	endtask
	// Start that must be refused, with no bytes sent
	task refuse(input logic [7:0] msg, input logic [7:0] st, input logic [1:0] m);
		apb(1'b1, `GKF_REG_CTRL, {8'h5A, st, msg, 8'h01});
		apb(1'b0, `GKF_REG_STATUS, 32'h0);
		`GKF_CHK("refused", m, rd[2:1])
		`GKF_CHK("busy_bit", 1'b0, rd[0])
		apb(1'b1, `GKF_REG_STATUS, 32'h0000000F);
		$display("Test refusal done");
	endtask
	// Scoreboard: oldest expectation against each captured byte
	always @(posedge clk) begin
		if (got === 1'b1) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("Error stream_byte expected none seen %0h", got_data);
			end else begin
				exp_b = exp_q.pop_front();
				`GKF_CHK("stream_byte", exp_b, got_data)
			end
		end
	end
	initial begin
		repeat (100000) @(posedge clk);
		tmo("run");
	end
	// Main sequence
	initial begin
		{rst, ce, psel, penable, pwrite, rx_valid, paddr, rx_byte, pwdata} = '0;
		rst = 1'b1;
		ce = 1'b1;
		dly = 4'h0;
		void'($urandom(32'hA6E1599F));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`GKF_CHK("enc_offset", 8'h00, tx_enc_offset)
		`GKF_CHK("ack_policy", 2'h1, tx_ack_policy)
		apb(1'b0, `GKF_REG_GADDR, 32'h0);
		`GKF_CHK("gaddr_reset", 32'h00000001, rd)
		apb(1'b0, 8'h50, 32'h0);
		`GKF_CHK("unmapped", 32'h0, rd)
		$display("Test reset done");
		keyid = 24'($urandom) | 24'h000100;
		rx_id = 24'($urandom) | 24'h000100;
		gaddr = 16'($urandom);
		cnt = {16'($urandom), $urandom};
		rx_cnt = {16'($urandom), $urandom};
		key = {$urandom, $urandom, $urandom, $urandom};
		apb(1'b1, `GKF_REG_KEYID, {8'h00, keyid});
		apb(1'b1, `GKF_REG_GADDR, {16'h0, gaddr});
		apb(1'b1, `GKF_REG_CNT_LO, cnt[31:0]);
		apb(1'b1, `GKF_REG_CNT_HI, {16'h0, cnt[47:32]});
		for (int i = 0; i < 4; i++) apb(1'b1, `GKF_REG_KEY0 + 8'(4 * i), key[32*i+:32]);
		gk(8'h00, 8'h00, 1'b0);
		rxb(8'h01);
		rxb(8'h00);
		for (int i = 0; i < 3; i++) rxb(rx_id[8*i+:8]);
		for (int i = 0; i < 5; i++) rxb(i < 3 ? 8'h00 : gaddr[8*(i-3)+:8]);
		for (int i = 0; i < 6; i++) rxb(rx_cnt[8*i+:8]);
		for (int i = 0; i < 16; i++) rxb(key[8*i+:8]);
		apb(1'b0, `GKF_REG_RX_KEYID, 32'h0);
		`GKF_CHK("rx_keyid", rx_id, rd[23:0])
		dly = 4'h5;
		gk(8'h01, 8'h01, 1'b1);
		dly = 4'h0;
		gk(8'h02, 8'h02, 1'b0);
		refuse(8'h00, 8'h03, 2'b10);
		apb(1'b1, `GKF_REG_KEYID, 32'h0);
		refuse(8'h01, 8'h00, 2'b01);
		apb(1'b1, `GKF_REG_KEYID, {8'h00, keyid});
		apb(1'b1, `GKF_REG_HELD0, {8'h00, keyid});
		refuse(8'h01, 8'h00, 2'b01);
		apb(1'b0, `GKF_REG_SFN, 32'h0);
		`GKF_CHK("sfn_reg", sfn_prev[31:0], rd)
		org = 16'($urandom);
		apb(1'b1, `GKF_REG_APP, {16'h0, org});
		push(org[7:0]);
		push(org[15:8], 1'b1);
		apb(1'b1, `GKF_REG_CTRL, 32'h00000005);
		done_wait("app_frame");
		`GKF_CHK("app_secure", 1'b0, tx_secure)
		apb(1'b1, `GKF_REG_IE, 32'h00000712);
		push(8'h12);
		push(8'h07, 1'b1);
		dly = 4'h3;
		apb(1'b1, `GKF_REG_CTRL, 32'h00000009);
		// Freeze mid-handshake: valid must hold though ready is up
		ce <= 1'b0;
		repeat (10) @(posedge clk);
		`GKF_CHK("ce_freeze", 1'b1, tx_valid)
		ce <= 1'b1;
		done_wait("ie_frame");
		conclude();
	end
endmodule // gkf_ctrl_bench
`default_nettype wire

// File: tb/gkf_dev_model.sv
// Device model that takes payload bytes over the four-phase stream
`default_nettype none
module gkf_dev_model (
	input  wire logic       clk,      // Bench clock
	input  wire logic       rst,      // Async reset, high
	input  wire logic [7:0] tx_byte,  // Offered byte
	input  wire logic       tx_valid, // Byte offered
	input  wire logic       tx_last,  // Last byte flag
	input  wire logic [3:0] dly,      // Cycles before accepting
	output logic            tx_ready, // Accept level
	output logic            got,      // One-cycle capture pulse
	output logic      [8:0] got_data  // Captured last flag and byte
);
	timeunit 1ns;
	timeprecision 1ns;
	// Accept loop: wait, accept, hold ready until valid drops
	initial begin
		tx_ready = 1'b0;
		got = 1'b0;
		got_data = '0;
		forever begin
			@(posedge clk);
			got <= 1'b0;
			if (tx_valid === 1'b1 && rst === 1'b0) begin
				repeat (dly) @(posedge clk);
				got_data <= {tx_last, tx_byte};
				got <= 1'b1;
				tx_ready <= 1'b1;
				// Four-phase: ready stays up while valid is up
				for (int i = 0; i < 64 && tx_valid === 1'b1; i++) begin
					@(posedge clk);
					got <= 1'b0;
				end
				tx_ready <= 1'b0;
			end
		end
	end
endmodule // gkf_dev_model
`default_nettype wire

// File: verilog/gkf_consts.svh
// Constants for the group-key command framer controller
// Function
// [RULE_01] Payload fields in fixed order and sizes
// [RULE_02] Group-key frame always sent protected
// [RULE_03] Encryption offset zero, from message number
// [RULE_04] Frame number is last plus one
// [RULE_05] Solicitation uses message number zero
// [RULE_06] Distribution uses message number one
// [RULE_07] Response uses message number two
// [RULE_08] Status codes zero, one, two; rest reserved
// [RULE_09] Solicit identifier sought or zero
// [RULE_10] Distribute identifier non-zero and unused
// [RULE_11] Response repeats last distributed identifier
// [RULE_12] Group address, 0x0001 means all traffic
// [RULE_13] Solicit counter sent zero, ignored on receipt
// [RULE_14] Distribute counter carries current frame counter
// [RULE_15] Response repeats last received counter
// [RULE_16] Solicit key field filled with zeros
// [RULE_17] Integrity code uses selected pairwise key
// [RULE_18] Header requests immediate acknowledgement
// [RULE_19] Application payload starts with organization specifier
// [RULE_20] Info element has identifier and length
// [RULE_21] Multi-byte fields sent low byte first
`ifndef GKF_CONSTS_SVH
`define GKF_CONSTS_SVH
`define GKF_PAYLOAD_LEN     6'd32
`define GKF_POS_MSG         6'd0
`define GKF_POS_STATUS      6'd1
`define GKF_POS_KEYID       6'd2
`define GKF_POS_RSVD        6'd5
`define GKF_POS_GADDR       6'd8
`define GKF_POS_CNT         6'd10
`define GKF_POS_KEY         6'd16
`define GKF_MSG_SOLICIT     8'h00
`define GKF_MSG_DISTRIB     8'h01
`define GKF_MSG_RESPONSE    8'h02
`define GKF_STATUS_OK       8'h00
`define GKF_STATUS_POLICY   8'h01
`define GKF_STATUS_HELD     8'h02
`define GKF_STATUS_MAX      8'h02
`define GKF_GADDR_ALL       16'h0001
`define GKF_ENC_OFFSET      8'h00
`define GKF_ACK_IMM         2'h1
`define GKF_REG_CTRL        8'h00
`define GKF_REG_STATUS      8'h04
`define GKF_REG_KEYID       8'h08
`define GKF_REG_GADDR       8'h0C
`define GKF_REG_CNT_LO      8'h10
`define GKF_REG_CNT_HI      8'h14
`define GKF_REG_KEY0        8'h18
`define GKF_REG_SFN         8'h28
`define GKF_REG_RX_KEYID    8'h2C
`define GKF_REG_RX_CNT_LO   8'h30
`define GKF_REG_RX_CNT_HI   8'h34
`define GKF_REG_HELD0       8'h38
`define GKF_REG_APP         8'h48
`define GKF_REG_IE          8'h4C
`endif

// File: verilog/gkf_ctrl.sv
// Group-key command framer controller with APB registers and byte stream
//
// The register offsets and the APB register port were decided locally.
`include "gkf_consts.svh"
`default_nettype none
module gkf_ctrl
	import gkf_pkg::*;
(
	input  wire logic        clk,          // 20 MHz clock
	input  wire logic        rst,          // Async reset, high
	input  wire logic        ce,           // Clock enable
	input  wire logic        psel,         // APB select
	input  wire logic        penable,      // APB enable
	input  wire logic        pwrite,       // APB direction
	input  wire logic [7:0]  paddr,        // APB byte address
	input  wire logic [31:0] pwdata,       // APB write data
	output logic      [31:0] prdata,       // APB read data
	output logic             pready,       // APB ready
	output logic             pslverr,      // APB error
	output logic      [7:0]  tx_byte,      // Payload byte out
	output logic             tx_valid,     // Byte valid
	input  wire logic        tx_ready,     // Device accepts byte (async)
	output logic             tx_last,      // Last byte of payload
	output logic             tx_secure,    // Frame protected flag
	output logic      [7:0]  tx_enc_offset,// Encryption offset
	output logic      [1:0]  tx_ack_policy,// Ack policy
	output logic      [47:0] tx_sfn,       // Secure frame number
	output logic      [7:0]  tx_temporal_key_identifier,      // Temporal key id for cipher
	input  wire logic [7:0]  rx_byte,      // Received payload byte (async)
	input  wire logic        rx_valid,     // Received byte strobe (async level)
	output logic             busy          // Transmission in progress
);
	// Synchronisers for async device inputs
	logic [1:0] rdy_s_q;                   // tx_ready sync
	logic [1:0] rxv_s_q;                   // rx_valid sync
	logic [7:0] rxb_s1_q, rxb_s2_q;        // rx_byte sync
	logic       rxv_prev_q;                // Edge memory
	// Control registers
	logic [7:0]   msg_q;                   // Message number
	logic [7:0]   status_q;                // Status code
	logic [23:0]  keyid_q;                 // Group key identifier
	logic [15:0]  gaddr_q;                 // Group target address
	logic [47:0]  cnt_q;                   // Key frame counter
	logic [127:0] key_q;                   // Group traffic key
	logic [47:0]  sfn_q;                   // Last secure frame number
	logic [7:0]   temporal_key_identifier_q;                  // Temporal key identifier
	logic [23:0]  rx_keyid_q;              // Last received distribution id
	logic [47:0]  rx_cnt_q;                // Last received counter
	logic [127:0] held_q;                  // Four held key identifiers
	logic [15:0]  org_q;                   // Organization specifier
	logic [15:0]  ie_q;                    // Info element id and length
	gkf_kind_t    kind_q;                  // Stream kind
	logic         bad_id_q;                // Identifier refused flag
	logic         bad_st_q;                // Status reserved flag
	logic         done_q;                  // Frame sent flag
	// Sequencer
	gkf_state_t   state_q;                 // Sequencer state
	logic [5:0]   idx_q;                   // Byte index
	logic [5:0]   rx_idx_q;                // Receive byte index
	logic         rx_dist_q;               // Receive frame is distribution
	logic [7:0]   frame_len;               // Bytes in frame
	logic [255:0] payload;                 // Assembled payload
	logic         id_clash;                // Identifier unusable
	logic         wr_en, rd_en;            // APB access
	logic         go;                      // Start request
	logic         go_q;                    // Start request, one cycle late
	// APB access on the access phase
	assign wr_en = psel & penable & pwrite & pready;
	assign rd_en = psel & penable & ~pwrite & pready;
	assign go    = wr_en & (paddr == `GKF_REG_CTRL) & pwdata[0] & (state_q == GKF_IDLE);
	// Start acted on one cycle late
	// The same CTRL write loads kind, message and status, so the
	// sequencer must not judge or send with the old field values
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			go_q <= 1'b0;
		end else if (ce) begin
			go_q <= go;
		end
	end
	// [RULE_10] Identifier check logic
	always_comb begin
		id_clash = (keyid_q == 24'h000000);
		for (int i = 0; i < 4; i++) begin
			if (held_q[i*32 +: 24] == keyid_q) begin
				id_clash = 1'b1;
			end
		end
	end
	// Frame length per kind
	always_comb begin
		unique case (kind_q)
			GKF_KIND_APP: frame_len = 8'h02;
			GKF_KIND_IE:  frame_len = 8'h02;
			default:      frame_len = {2'b00, `GKF_PAYLOAD_LEN};
		endcase
	end
	// Payload assembly, low byte first
	always_comb begin
		payload = '0;
		unique case (kind_q)
			// [RULE_19] Organization specifier low byte first
			GKF_KIND_APP: payload[15:0] = org_q;
			// [RULE_20] Element id then length
			GKF_KIND_IE:  payload[15:0] = ie_q;
			default: begin
				// [RULE_01] Field order in payload
				payload[8*`GKF_POS_MSG +: 8]    = msg_q;
				payload[8*`GKF_POS_STATUS +: 8] = status_q;
				// [RULE_09] Solicitation and distribution identifier
				payload[8*`GKF_POS_KEYID +: 24] = keyid_q;
				// [RULE_07] Response carries message number two
				// [RULE_11] Response repeats received identifier
				if (msg_q == `GKF_MSG_RESPONSE) begin
					payload[8*`GKF_POS_KEYID +: 24] = rx_keyid_q;
				end
				// [RULE_12] Group target address field
				payload[8*`GKF_POS_GADDR +: 16] = gaddr_q;
				// [RULE_14] Distribution counter is current value
				payload[8*`GKF_POS_CNT +: 48] = cnt_q;
				// [RULE_15] Response repeats received counter
				if (msg_q == `GKF_MSG_RESPONSE) begin
					payload[8*`GKF_POS_CNT +: 48] = rx_cnt_q;
				end
				// [RULE_13] Solicitation counter sent as zero
				if (msg_q == `GKF_MSG_SOLICIT) begin
					payload[8*`GKF_POS_CNT +: 48] = 48'h000000000000;
				end
				// [RULE_16] Solicitation key zero filled
				payload[8*`GKF_POS_KEY +: 128] = (msg_q == `GKF_MSG_SOLICIT) ? '0 : key_q;
			end
		endcase
	end
	// Synchronise device inputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdy_s_q    <= 2'b00;
			rxv_s_q    <= 2'b00;
			rxb_s1_q   <= 8'h00;
			rxb_s2_q   <= 8'h00;
			rxv_prev_q <= 1'b0;
		end else if (ce) begin
			rdy_s_q    <= {rdy_s_q[0], tx_ready};
			rxv_s_q    <= {rxv_s_q[0], rx_valid};
			rxb_s1_q   <= rx_byte;
			rxb_s2_q   <= rxb_s1_q;
			rxv_prev_q <= rxv_s_q[1];
		end
	end
	// Receive parser: capture identifier and counter of distributions
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_idx_q   <= 6'd0;
			rx_dist_q  <= 1'b0;
			rx_keyid_q <= 24'h000000;
			rx_cnt_q   <= 48'h000000000000;
		end else if (ce && rxv_s_q[1] && !rxv_prev_q) begin
			rx_idx_q <= (rx_idx_q == `GKF_PAYLOAD_LEN - 6'd1) ? 6'd0 : rx_idx_q + 6'd1;
			if (rx_idx_q == `GKF_POS_MSG) begin
				// [RULE_06] Recognise distribution message
				rx_dist_q <= (rxb_s2_q == `GKF_MSG_DISTRIB);
			end
			// [RULE_21] Low byte first on receive
			if (rx_dist_q && rx_idx_q >= `GKF_POS_KEYID && rx_idx_q < `GKF_POS_RSVD) begin
				rx_keyid_q[8*(rx_idx_q - `GKF_POS_KEYID) +: 8] <= rxb_s2_q;
			end
			if (rx_dist_q && rx_idx_q >= `GKF_POS_CNT && rx_idx_q < `GKF_POS_KEY) begin
				rx_cnt_q[8*(rx_idx_q - `GKF_POS_CNT) +: 8] <= rxb_s2_q;
			end
		end
	end
	// Software-written registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			msg_q    <= `GKF_MSG_SOLICIT;
			status_q <= `GKF_STATUS_OK;
			keyid_q  <= 24'h000000;
			gaddr_q  <= `GKF_GADDR_ALL;
			cnt_q    <= 48'h000000000000;
			key_q    <= '0;
			temporal_key_identifier_q   <= 8'h00;
			held_q   <= '0;
			org_q    <= 16'h0000;
			ie_q     <= 16'h0000;
			kind_q   <= GKF_KIND_GK;
		end else if (ce && wr_en) begin
			unique case (paddr)
				`GKF_REG_CTRL: begin
					// [RULE_05] Message number chosen by software
					msg_q  <= pwdata[15:8];
					// [RULE_08] Status code field
					status_q <= pwdata[23:16];
					kind_q <= gkf_kind_t'(pwdata[3:2]);
					temporal_key_identifier_q <= pwdata[31:24];
				end
				`GKF_REG_KEYID:  keyid_q <= pwdata[23:0];
				`GKF_REG_GADDR:  gaddr_q <= pwdata[15:0];
				`GKF_REG_CNT_LO: cnt_q[31:0] <= pwdata;
				`GKF_REG_CNT_HI: cnt_q[47:32] <= pwdata[15:0];
				`GKF_REG_APP:    org_q <= pwdata[15:0];
				`GKF_REG_IE:     ie_q <= pwdata[15:0];
				default: begin
					if (paddr >= `GKF_REG_KEY0 && paddr < `GKF_REG_SFN) begin
						key_q[8*(paddr - `GKF_REG_KEY0) +: 32] <= pwdata;
					end
					if (paddr >= `GKF_REG_HELD0 && paddr < `GKF_REG_APP) begin
						held_q[8*(paddr - `GKF_REG_HELD0) +: 32] <= pwdata;
					end
				end
			endcase
		end
	end
	// Transmit sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q  <= GKF_IDLE;
			idx_q    <= 6'd0;
			tx_byte  <= 8'h00;
			tx_valid <= 1'b0;
			tx_last  <= 1'b0;
			busy     <= 1'b0;
			sfn_q    <= 48'h000000000000;
			bad_id_q <= 1'b0;
			bad_st_q <= 1'b0;
			done_q   <= 1'b0;
		end else if (ce) begin
			unique case (state_q)
				GKF_IDLE: begin
					if (go_q) begin
						// [RULE_10] Refuse unusable distribution id
						if (kind_q == GKF_KIND_GK && msg_q == `GKF_MSG_DISTRIB && id_clash) begin
							bad_id_q <= 1'b1;
						end else if (kind_q == GKF_KIND_GK && status_q > `GKF_STATUS_MAX) begin
							// [RULE_08] Reserved status refused
							bad_st_q <= 1'b1;
						end else begin
							// [RULE_04] Next secure frame number
							if (kind_q == GKF_KIND_GK) begin
								sfn_q <= sfn_q + 48'd1;
							end
							done_q   <= 1'b0;
							busy     <= 1'b1;
							idx_q    <= 6'd0;
							tx_byte  <= payload[7:0];
							tx_valid <= 1'b1;
							tx_last  <= (frame_len == 8'h01);
							state_q  <= GKF_TX;
						end
					end else if (wr_en && paddr == `GKF_REG_STATUS) begin
						bad_id_q <= bad_id_q & ~pwdata[1];
						bad_st_q <= bad_st_q & ~pwdata[2];
						done_q   <= done_q & ~pwdata[3];
					end
				end
				GKF_TX: begin
					// Byte taken once device ready seen
					if (rdy_s_q[1]) begin
						tx_valid <= 1'b0;
						state_q  <= GKF_WAIT;
					end
				end
				default: begin
					// Wait for ready to drop, then next byte
					if (!rdy_s_q[1]) begin
						if ({2'b00, idx_q} == frame_len - 8'd1) begin
							busy    <= 1'b0;
							done_q  <= 1'b1;
							tx_last <= 1'b0;
							state_q <= GKF_IDLE;
						end else begin
							// [RULE_21] Next byte, low first
							idx_q    <= idx_q + 6'd1;
							tx_byte  <= payload[8*(idx_q + 6'd1) +: 8];
							tx_last  <= ({2'b00, idx_q} == frame_len - 8'd2);
							tx_valid <= 1'b1;
							state_q  <= GKF_TX;
						end
					end
				end
			endcase
		end
	end
	// Frame header settings toward the device
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_secure     <= 1'b1;
			tx_enc_offset <= `GKF_ENC_OFFSET;
			tx_ack_policy <= `GKF_ACK_IMM;
			tx_sfn        <= 48'h000000000000;
			tx_temporal_key_identifier       <= 8'h00;
		end else if (ce) begin
			// [RULE_02] Group-key frames always protected
			tx_secure     <= (kind_q == GKF_KIND_GK);
			// [RULE_03] Encryption starts at message number
			tx_enc_offset <= `GKF_ENC_OFFSET;
			// [RULE_18] Immediate acknowledgement requested
			tx_ack_policy <= `GKF_ACK_IMM;
			tx_sfn        <= sfn_q;
			// [RULE_17] Pairwise key selection for integrity code
			tx_temporal_key_identifier       <= temporal_key_identifier_q;
		end
	end
	// APB read path, zero wait states
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`GKF_REG_CTRL:      prdata <= {temporal_key_identifier_q, status_q, msg_q, 4'h0, kind_q, 2'b00};
					`GKF_REG_STATUS:    prdata <= {28'h0000000, done_q, bad_st_q, bad_id_q, busy};
					`GKF_REG_KEYID:     prdata <= {8'h00, keyid_q};
					`GKF_REG_GADDR:     prdata <= {16'h0000, gaddr_q};
					`GKF_REG_CNT_LO:    prdata <= cnt_q[31:0];
					`GKF_REG_CNT_HI:    prdata <= {16'h0000, cnt_q[47:32]};
					`GKF_REG_SFN:       prdata <= sfn_q[31:0];
					`GKF_REG_RX_KEYID:  prdata <= {8'h00, rx_keyid_q};
					`GKF_REG_RX_CNT_LO: prdata <= rx_cnt_q[31:0];
					`GKF_REG_RX_CNT_HI: prdata <= {16'h0000, rx_cnt_q[47:32]};
					`GKF_REG_APP:       prdata <= {16'h0000, org_q};
					`GKF_REG_IE:        prdata <= {16'h0000, ie_q};
					default:            prdata <= 32'h00000000;
				endcase
			end
		end
	end
	// [RULE_02] Group-key frames flagged protected
	a_secure_flag: assert property (@(posedge clk) disable iff (rst) // RULE_02
		ce && kind_q == GKF_KIND_GK && $stable(kind_q) |=> tx_secure)
		else $error("group-key frame not protected");
	// [RULE_03] Offset always zero
	a_enc_offset: assert property (@(posedge clk) disable iff (rst) // RULE_03
		tx_enc_offset == 8'h00)
		else $error("encryption offset nonzero");
	// [RULE_04] Frame number advances by one
	a_sfn_step: assert property (@(posedge clk) disable iff (rst) // RULE_04
		ce && go_q && kind_q == GKF_KIND_GK && !id_clash && status_q <= 8'h02
		|=> sfn_q == $past(sfn_q) + 48'd1)
		else $error("frame number not incremented");
	// [RULE_13] Solicit counter zero
	a_solicit_cnt: assert property (@(posedge clk) disable iff (rst) // RULE_13
		kind_q == GKF_KIND_GK && msg_q == 8'h00 |-> payload[127:80] == '0)
		else $error("solicit counter not zero");
	// [RULE_16] Solicit key zero
	a_solicit_key: assert property (@(posedge clk) disable iff (rst) // RULE_16
		kind_q == GKF_KIND_GK && msg_q == 8'h00 |-> payload[255:128] == '0)
		else $error("solicit key not zero");
	// [RULE_11] Response repeats received id
	a_resp_keyid: assert property (@(posedge clk) disable iff (rst) // RULE_11
		kind_q == GKF_KIND_GK && msg_q == 8'h02 |-> payload[39:16] == rx_keyid_q)
		else $error("response id mismatch");
	// [RULE_10] Zero distribution id refused
	a_dist_refuse: assert property (@(posedge clk) disable iff (rst) // RULE_10
		ce && go_q && kind_q == GKF_KIND_GK && msg_q == 8'h01 && keyid_q == 24'h0
		|=> bad_id_q && !busy)
		else $error("zero id not refused");
	// [RULE_18] Immediate acknowledgement
	a_ack_imm: assert property (@(posedge clk) disable iff (rst) // RULE_18
		tx_ack_policy == 2'h1)
		else $error("ack policy wrong");
	// Application frame started
	c_app_frame: cover property (@(posedge clk) disable iff (rst) go_q && kind_q == GKF_KIND_APP);
	c_frame_done: cover property (@(posedge clk) disable iff (rst) $rose(done_q));
	c_refused: cover property (@(posedge clk) disable iff (rst) $rose(bad_id_q));
	c_rx_dist: cover property (@(posedge clk) disable iff (rst) $changed(rx_keyid_q));
endmodule // gkf_ctrl
`default_nettype wire

// File: verilog/gkf_pkg.sv
// Types for the group-key command framer controller
`default_nettype none
package gkf_pkg;
	// Transmit sequencer states
	typedef enum logic [1:0] {GKF_IDLE, GKF_TX, GKF_WAIT} gkf_state_t;
	// Byte stream selection
	typedef enum logic [1:0] {GKF_KIND_GK, GKF_KIND_APP, GKF_KIND_IE} gkf_kind_t;
endpackage
`default_nettype wire
